// *** logic/sram_sleep_pkg.sv ***
// constants and types shared by the sram sleep and cycle qualify logic
package sram_sleep_pkg;
  // ==========================================================
  // widths
  localparam int unsigned ADDR_W = 19;
  localparam int unsigned DATA_W = 18;
  // ==========================================================
  // latencies, in clock cycles
  localparam int unsigned ENTRY_CYC = 2;
  localparam int unsigned EXIT_CYC = 2;
  localparam int unsigned CNT_W = 2;
  localparam logic [CNT_W-1:0] ENTRY_CNT = CNT_W'(ENTRY_CYC);
  localparam logic [CNT_W-1:0] EXIT_CNT = CNT_W'(EXIT_CYC);
  localparam logic [CNT_W-1:0] CNT_RST = 2'h0;
  // ==========================================================
  // reset values
  localparam logic [ADDR_W-1:0] ADDR_RST = 19'h0_0000;
  localparam logic [DATA_W-1:0] DATA_RST = 18'h0_0000;
  // ==========================================================
  // power state
  typedef enum logic [1:0] {PWR_AWAKE, PWR_ENTER, PWR_SLEEP, PWR_EXIT} pwr_state_t;
  // cycle kinds
  typedef enum logic [1:0] {CYC_IDLE, CYC_READ, CYC_WRITE} cyc_kind_t;
endpackage : sram_sleep_pkg

// *** logic/sleep_sync.sv ***
// two flip-flop synchroniser for the asynchronous sleep request
`timescale 1ns/1ns
`default_nettype none
module sleep_sync (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic async_i,
  output logic sync_o
);
  logic meta_q;
  logic meta_d;
  logic sync_q;
  logic sync_d;
  // ==========================================================
  // synchroniser stages; first stage feeds only the second
  always_comb begin
    meta_d = async_i;
    sync_d = meta_q;
  end
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end
  assign sync_o = sync_q;
endmodule : sleep_sync
`default_nettype wire

// *** logic/sram_sleep_qualify.sv ***
// sleep entry and exit plus read and write cycle qualification of a synchronous sram
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - sleep request is asynchronous and active high; high means enter sleep.
// - sleep lasts while the request is high; leaves only once it returns low.
// - asleep, all inputs except sleep request ignored, data outputs high impedance.
// - after request rises, synchronous input sampling stops within no fewer than two cycles.
// - after request falls, sampling resumes only after two cycles elapse.
// - write begins where write strobe low and address advance low on an edge.
// - read begins where write strobe high and address advance low on an edge.
// - new address captured only when address advance and chip select both low.
module sram_sleep_qualify (
  input wire logic CLK_I,
  input wire logic RST_B_I,
  input wire logic SLEEP_REQUEST_I,
  input wire logic CHIP_SEL_N_I,
  input wire logic ADDRESS_ADVANCE_N_I,
  input wire logic WRITE_N_I,
  input wire logic [sram_sleep_pkg::ADDR_W-1:0] ADDR_I,
  input wire logic [sram_sleep_pkg::DATA_W-1:0] DATA_I,
  input wire logic [sram_sleep_pkg::DATA_W-1:0] RDATA_I,
  output logic [sram_sleep_pkg::DATA_W-1:0] DATA_O,
  output logic DATA_OE_O,
  output logic SLEEPING_O,
  output logic SAMPLING_O,
  output logic [sram_sleep_pkg::ADDR_W-1:0] ADDR_O,
  output logic ADDR_STB_O,
  output logic READ_STB_O,
  output logic WRITE_STB_O,
  output logic [sram_sleep_pkg::DATA_W-1:0] WDATA_O
);
  import sram_sleep_pkg::*;

  logic req_sync;
  pwr_state_t state_q;
  pwr_state_t state_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic sampling_q;
  logic sampling_d;
  logic sleeping_q;
  logic sleeping_d;
  logic [ADDR_W-1:0] addr_q;
  logic [ADDR_W-1:0] addr_d;
  logic addr_stb_q;
  logic addr_stb_d;
  logic read_stb_q;
  logic read_stb_d;
  logic write_stb_q;
  logic write_stb_d;
  logic [DATA_W-1:0] wdata_q;
  logic [DATA_W-1:0] wdata_d;
  logic [DATA_W-1:0] dout_q;
  logic [DATA_W-1:0] dout_d;
  logic oe_q;
  logic oe_d;
  logic rd_pend_q;
  logic rd_pend_d;
  cyc_kind_t kind;
  logic take;

  // ==========================================================
  // sleep request crossing
  sleep_sync u_sync (
    .clk_i(CLK_I),
    .rst_b_i(RST_B_I),
    .async_i(SLEEP_REQUEST_I),
    .sync_o(req_sync)
  );

  // ==========================================================
  // power state machine; counter times only the exit latency
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    sampling_d = sampling_q;
    sleeping_d = sleeping_q;
    case (state_q)
      PWR_AWAKE: begin
        if (req_sync) begin
          state_d = PWR_ENTER;
          cnt_d = CNT_RST;
        end
      end
      PWR_ENTER: begin
        // the synchroniser already eats part of the entry latency
        sleeping_d = 1'b1;
        sampling_d = 1'b0;
        state_d = PWR_SLEEP;
      end
      PWR_SLEEP: begin
        if (!req_sync) begin
          state_d = PWR_EXIT;
          cnt_d = CNT_RST;
        end
      end
      PWR_EXIT: begin
        sleeping_d = 1'b0;
        if (req_sync) begin
          state_d = PWR_SLEEP; // request back high, stay down
          sleeping_d = 1'b1;
        end else if (cnt_q == EXIT_CNT - 2'h1) begin
          state_d = PWR_AWAKE;
          sampling_d = 1'b1;
        end else begin
          cnt_d = cnt_q + 2'h1;
        end
      end
      default: begin
        state_d = PWR_AWAKE;
        sampling_d = 1'b1;
        sleeping_d = 1'b0;
      end
    endcase
  end
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      state_q <= PWR_AWAKE;
      cnt_q <= CNT_RST;
      sampling_q <= 1'b1;
      sleeping_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      sampling_q <= sampling_d;
      sleeping_q <= sleeping_d;
    end
  end

  // ==========================================================
  // cycle decode; only while sampling
  assign take = sampling_q && !ADDRESS_ADVANCE_N_I && !CHIP_SEL_N_I;
  always_comb begin
    kind = CYC_IDLE;
    if (take && !WRITE_N_I) begin
      kind = CYC_WRITE;
    end else if (take) begin
      kind = CYC_READ;
    end
  end

  // ==========================================================
  // address capture, strobes and data path
  always_comb begin
    addr_d = addr_q;
    wdata_d = wdata_q;
    addr_stb_d = 1'b0;
    read_stb_d = 1'b0;
    write_stb_d = 1'b0;
    rd_pend_d = 1'b0;
    dout_d = dout_q;
    oe_d = 1'b0;
    if (take) begin
      addr_d = ADDR_I;
      addr_stb_d = 1'b1;
    end
    if (kind == CYC_WRITE) begin
      write_stb_d = 1'b1;
      wdata_d = DATA_I;
    end
    if (kind == CYC_READ) begin
      read_stb_d = 1'b1;
      rd_pend_d = 1'b1;
    end
    // pipelined read data one cycle after the strobe
    if (rd_pend_q && sampling_q) begin
      dout_d = RDATA_I;
      oe_d = 1'b1;
    end
    // sleep forces the bus off regardless of reads in flight
    if (!sampling_q || req_sync) begin
      oe_d = 1'b0;
    end
  end
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      addr_q <= ADDR_RST;
      wdata_q <= DATA_RST;
      addr_stb_q <= 1'b0;
      read_stb_q <= 1'b0;
      write_stb_q <= 1'b0;
      rd_pend_q <= 1'b0;
      dout_q <= DATA_RST;
      oe_q <= 1'b0;
    end else begin
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      addr_stb_q <= addr_stb_d;
      read_stb_q <= read_stb_d;
      write_stb_q <= write_stb_d;
      rd_pend_q <= rd_pend_d;
      dout_q <= dout_d;
      oe_q <= oe_d;
    end
  end

  assign DATA_O = dout_q;
  assign DATA_OE_O = oe_q;
  assign SLEEPING_O = sleeping_q;
  assign SAMPLING_O = sampling_q;
  assign ADDR_O = addr_q;
  assign ADDR_STB_O = addr_stb_q;
  assign READ_STB_O = read_stb_q;
  assign WRITE_STB_O = write_stb_q;
  assign WDATA_O = wdata_q;

  // ==========================================================
  // checks
  AST_SLEEP_NO_OE: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    SLEEPING_O |-> !DATA_OE_O) else $error("data driven while asleep");
  AST_ENTRY_LATENCY: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    $rose(SLEEP_REQUEST_I) |-> SAMPLING_O ##1 SAMPLING_O)
    else $error("sampling stopped too soon");
  // two sync edges, one state edge, then the flag edge: low from the fifth edge on
  AST_ENTRY_BOUND: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    $rose(SLEEP_REQUEST_I) ##1 SLEEP_REQUEST_I[*4] |-> !SAMPLING_O)
    else $error("sleep not entered");
  AST_EXIT_LATENCY: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    $fell(SLEEP_REQUEST_I) |-> !SAMPLING_O ##1 !SAMPLING_O)
    else $error("sampling resumed too soon");
  AST_STAY_ASLEEP: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    SLEEPING_O && $past(SLEEP_REQUEST_I) && SLEEP_REQUEST_I |=> SLEEPING_O)
    else $error("left sleep while request high");
  AST_EXIT_BOUND: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    SLEEPING_O ##1 !SLEEP_REQUEST_I[*6] |-> SAMPLING_O)
    else $error("sleep not left");
  AST_ADDR_QUAL: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    ADDR_STB_O |-> !$past(ADDRESS_ADVANCE_N_I) && !$past(CHIP_SEL_N_I) && $past(SAMPLING_O))
    else $error("address captured without qualify");
  AST_WRITE_QUAL: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    WRITE_STB_O |-> !$past(WRITE_N_I) && ADDR_STB_O)
    else $error("write without low strobe");
  AST_READ_QUAL: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    READ_STB_O |-> $past(WRITE_N_I) && ADDR_STB_O)
    else $error("read without high strobe");
  AST_ADDR_HOLD: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    !ADDR_STB_O |-> $stable(ADDR_O)) else $error("address changed unqualified");
  COV_SLEEP: cover property (@(posedge CLK_I) disable iff (!RST_B_I) $rose(SLEEPING_O));
  COV_WAKE: cover property (@(posedge CLK_I) disable iff (!RST_B_I) $rose(SAMPLING_O));
  COV_WRITE: cover property (@(posedge CLK_I) disable iff (!RST_B_I) WRITE_STB_O);
  COV_READ_DATA: cover property (@(posedge CLK_I) disable iff (!RST_B_I) READ_STB_O ##1 DATA_OE_O);
endmodule : sram_sleep_qualify
`default_nettype wire

// *** dv/sram_ctrl_model.sv ***
// controller model driving the sram bus pins on bench command
`timescale 1ns/1ns
`default_nettype none
module sram_ctrl_model (
  input wire logic clk_i,
  output logic sleep_request_o,
  output logic chip_sel_n_o,
  output logic address_advance_n_o,
  output logic write_n_o,
  output logic [sram_sleep_pkg::ADDR_W-1:0] addr_o,
  output logic [sram_sleep_pkg::DATA_W-1:0] data_o,
  output logic [sram_sleep_pkg::DATA_W-1:0] rdata_o
);
  import sram_sleep_pkg::*;
  // ==========================================================
  // idle bus: deselected, no advance
  initial begin
    sleep_request_o = 1'b0;
    chip_sel_n_o = 1'b1;
    address_advance_n_o = 1'b1;
    write_n_o = 1'b1;
    addr_o = ADDR_RST;
    data_o = DATA_RST;
    rdata_o = DATA_RST;
  end
  // ==========================================================
  // one cycle; strobe and select held together on one edge
  task automatic access(input logic cs_n, input logic wr_n,
                        input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk_i);
    chip_sel_n_o <= cs_n;
    address_advance_n_o <= 1'b0;
    write_n_o <= wr_n;
    addr_o <= a;
    data_o <= d;
    rdata_o <= ~d; // array word, held through the data edge
    @(posedge clk_i);
    chip_sel_n_o <= 1'b1;
    address_advance_n_o <= 1'b1;
    addr_o <= ~a; // stale values never look valid
    data_o <= d ^ 18'h1_5555;
  endtask : access
  // called only between accesses, so nothing is pending at entry
  task automatic sleep(input logic lvl);
    @(posedge clk_i);
    sleep_request_o <= lvl;
  endtask : sleep
endmodule : sram_ctrl_model
`default_nettype wire

// *** dv/sram_sleep_qualify_tb_top.sv ***
// self-checking bench for the sram sleep and cycle qualify block
`timescale 1ns/1ns
`default_nettype none
module sram_sleep_qualify_tb_top;
  import sram_sleep_pkg::*;
  logic clk;
  logic rst_b;
  logic sleep_req;
  logic cs_n;
  logic adv_n;
  logic wr_n;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;
  logic [DATA_W-1:0] data_o;
  logic data_oe;
  logic sleeping;
  logic sampling;
  logic [ADDR_W-1:0] addr_o;
  logic addr_stb;
  logic read_stb;
  logic write_stb;
  logic [DATA_W-1:0] wdata_o;
  int miscompares = 0;
  int check_count = 0;
  int n;
  // ==========================================================
  // clock, design and controller model
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  sram_sleep_qualify DUT (.CLK_I(clk), .RST_B_I(rst_b), .SLEEP_REQUEST_I(sleep_req),
    .CHIP_SEL_N_I(cs_n), .ADDRESS_ADVANCE_N_I(adv_n), .WRITE_N_I(wr_n), .ADDR_I(addr),
    .DATA_I(wdata), .RDATA_I(rdata), .DATA_O(data_o), .DATA_OE_O(data_oe),
    .SLEEPING_O(sleeping), .SAMPLING_O(sampling), .ADDR_O(addr_o), .ADDR_STB_O(addr_stb),
    .READ_STB_O(read_stb), .WRITE_STB_O(write_stb), .WDATA_O(wdata_o));
  sram_ctrl_model ctrl (.clk_i(clk), .sleep_request_o(sleep_req), .chip_sel_n_o(cs_n),
    .address_advance_n_o(adv_n), .write_n_o(wr_n), .addr_o(addr), .data_o(wdata),
    .rdata_o(rdata));
  // ==========================================================
  // compare and closing
  task automatic chk(input logic [ADDR_W-1:0] got, input logic [ADDR_W-1:0] exp,
                     input string msg);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk
  // data words compared at their own width, so inversions do not spill a bit
  task automatic chk_data(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp,
                          input string msg);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk_data
  task automatic give_verdict();
    if (miscompares == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : give_verdict
  // bounded wait on a level; running out ends the run
  task automatic wait_lvl(input logic want_sleep, input logic lvl);
    for (n = 0; n < 8; n++) begin
      if ((want_sleep ? sleeping : sampling) === lvl) return;
      @(posedge clk);
      #1;
    end
    miscompares++;
    $display("BAD %0t wait ran out", $time);
    give_verdict();
  endtask : wait_lvl
  // ==========================================================
  // scenarios
  task automatic t_write();
    ctrl.access(1'b0, 1'b0, 19'h5_a5a5, 18'h2_3c3c);
    #1;
    chk(addr_stb, 1'b1, "addr strobe");
    chk(write_stb, 1'b1, "write strobe");
    chk(read_stb, 1'b0, "read on write");
    chk(addr_o, 19'h5_a5a5, "addr");
    chk_data(wdata_o, 18'h2_3c3c, "wdata");
  endtask : t_write
  task automatic t_read(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    ctrl.access(1'b0, 1'b1, a, d);
    #1;
    chk(read_stb, 1'b1, "read strobe");
    chk(write_stb, 1'b0, "write on read");
    chk(addr_o, a, "read addr");
    @(posedge clk);
    #1;
    chk(data_oe, 1'b1, "oe");
    chk_data(data_o, ~d, "rdata");
  endtask : t_read
  // deselected edge captures nothing
  task automatic t_desel();
    ctrl.access(1'b1, 1'b1, 19'h0_1234, 18'h0_0f0f);
    #1;
    chk(addr_stb, 1'b0, "desel strobe");
    chk(addr_o, 19'h7_fffe, "addr kept");
  endtask : t_desel
  task automatic t_sleep();
    ctrl.sleep(1'b1);
    @(posedge clk);
    #1;
    chk(sampling, 1'b1, "early stop");
    wait_lvl(1'b1, 1'b1);
    chk(sampling, 1'b0, "asleep sampling");
    ctrl.access(1'b0, 1'b0, 19'h1_1111, 18'h0_2222);
    #1;
    chk(addr_stb, 1'b0, "asleep capture");
    @(posedge clk);
    #1;
    chk(data_oe, 1'b0, "asleep oe");
    repeat (10) @(posedge clk);
    #1;
    chk(sleeping, 1'b1, "stays asleep");
    ctrl.sleep(1'b0);
    repeat (2) begin
      @(posedge clk);
      #1;
      chk(sampling, 1'b0, "early resume");
    end
    wait_lvl(1'b0, 1'b1);
    chk(sleeping, 1'b0, "awake");
    t_read(19'h3_0303, 18'h1_0101);
  endtask : t_sleep
  // ==========================================================
  // main sequence
  initial begin
    rst_b = 1'b0;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    #1;
    chk(sampling, 1'b1, "reset sampling");
    chk(data_oe, 1'b0, "reset oe");
    t_write();
    t_read(19'h7_fffe, 18'h3_ffff);
    t_desel();
    t_sleep();
    give_verdict();
  end
endmodule : sram_sleep_qualify_tb_top
`default_nettype wire
